// file: rtl/vxu_exec_cluster.sv
// Operation
// [RL1] Bundle: four ALU, two MUL, two FPU slots
// [RL2] Whole bundle dispatched together in one cycle
// [RL3] Four identical ALUs, scalar and SIMD
// [RL4] ALU result ready for next bundle
// [RL5] ALU takes two words, two conditions
// [RL6] ALU yields one word, one condition
// [RL7] Two FPUs: add, subtract, conversions
// [RL8] FPU pipeline three cycles deep
// [RL9] FPU takes two words, one result
// [RL10] Two multipliers, three deep, every cycle
// [RL11] Multiplier: integer, SIMD, float, multiply-add
// [RL12] Multiplier takes two words, one result
// [RL13] Divider three deep, accepts every cycle
// [RL14] Divider takes two words, one result
// [RL15] Slow divide stalls until result ready
// [RL16] Stall holds all stages, refuses issue
`default_nettype none
`include "vxu_map.svh"

module vxu_exec_cluster #(
    parameter int DIV_EXTRA = `VXU_DIV_EXTRA
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  resetn,
    // Bundle issue
    input  wire logic                  issueValid,
    output logic                       issueReady,
    input  wire vxu_pkg::vxu_aluissue_s aluIn [`VXU_NUM_ALU], // [RL1]
    input  wire vxu_pkg::vxu_mulissue_s mulIn [`VXU_NUM_MUL], // [RL1]
    input  wire vxu_pkg::vxu_fpuissue_s fpuIn [`VXU_NUM_FPU], // [RL1]
    input  wire vxu_pkg::vxu_divissue_s divIn,
    // Results and stall
    output vxu_pkg::vxu_alures_s       aluRes [`VXU_NUM_ALU],
    output vxu_pkg::vxu_res_s          mulRes [`VXU_NUM_MUL],
    output vxu_pkg::vxu_res_s          fpuRes [`VXU_NUM_FPU],
    output vxu_pkg::vxu_res_s          divRes,
    output logic                       stall
);

    localparam int D = `VXU_PIPE_DEPTH;
    localparam int NA = `VXU_NUM_ALU;
    localparam int NM = `VXU_NUM_MUL;
    localparam int NF = `VXU_NUM_FPU;

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic functions

    function automatic vxu_pkg::vxu_alures_s aluCalc(input vxu_pkg::vxu_aluissue_s i);
        vxu_pkg::vxu_alures_s r;
        r = '0;
        r.valid = 1'b1;
        unique case (i.op)
            vxu_pkg::VXU_ALU_ADD:   r.data = i.a + i.b;
            vxu_pkg::VXU_ALU_SUB:   r.data = i.a - i.b;
            vxu_pkg::VXU_ALU_AND:   r.data = i.a & i.b;
            vxu_pkg::VXU_ALU_OR:    r.data = i.a | i.b;
            vxu_pkg::VXU_ALU_XOR:   r.data = i.a ^ i.b;
            vxu_pkg::VXU_ALU_SHL:   r.data = i.a << i.b[4:0];
            vxu_pkg::VXU_ALU_SHR:   r.data = i.a >> i.b[4:0];
            vxu_pkg::VXU_ALU_ADD8:  for (int k = 0; k < 4; k++) begin
                                        r.data[8*k +: 8] = i.a[8*k +: 8] + i.b[8*k +: 8];
                                    end
            vxu_pkg::VXU_ALU_ADD16: for (int k = 0; k < 2; k++) begin
                                        r.data[16*k +: 16] = i.a[16*k +: 16] + i.b[16*k +: 16];
                                    end
            vxu_pkg::VXU_ALU_CMPEQ: begin
                r.valid = 1'b0;
                r.condValid = 1'b1;
                r.cond = {3'h0, i.a == i.b};
            end
            vxu_pkg::VXU_ALU_SEL:   r.data = i.ca[0] ? i.a : i.b;
            // Condition-only op: no word result
            vxu_pkg::VXU_ALU_CAND:  begin
                r.valid = 1'b0;
                r.condValid = 1'b1;
                r.cond = i.ca & i.cb;
            end
            default:                r.data = '0;
        endcase
        return r;
    endfunction : aluCalc

    // Simplified float: truncation, no denormals, no special values
    function automatic vxu_pkg::vxu_word_t fNorm(input logic s, input logic [8:0] e,
                                                  input logic [25:0] m);
        logic [8:0]  ee;
        logic [25:0] mm;
        ee = e;
        mm = m;
        if (mm == '0) begin
            return '0;
        end
        for (int k = 0; k < 26; k++) begin
            if (!mm[25]) begin
                mm = mm << 1;
                ee = ee - 9'h001;
            end
        end
        // Leading one now at bit 25; mantissa field is bits 24:2
        return {s, ee[7:0] + 8'h02, mm[24:2]};
    endfunction : fNorm

    function automatic vxu_pkg::vxu_word_t fAdd(input vxu_pkg::vxu_word_t a,
                                                 input vxu_pkg::vxu_word_t b);
        logic [7:0]  diff;
        logic [25:0] ma;
        logic [25:0] mb;
        vxu_pkg::vxu_word_t x;
        vxu_pkg::vxu_word_t y;
        x = (a[30:0] >= b[30:0]) ? a : b;
        y = (a[30:0] >= b[30:0]) ? b : a;
        diff = x[30:23] - y[30:23];
        ma = {2'h0, 1'b1, x[22:0]};
        mb = (diff > 8'h19) ? 26'h0 : ({2'h0, 1'b1, y[22:0]} >> diff);
        return fNorm(x[31], {1'b0, x[30:23]},
                     (x[31] == y[31]) ? ma + mb : ma - mb);
    endfunction : fAdd

    function automatic vxu_pkg::vxu_word_t fpuCalc(input vxu_pkg::vxu_fpuissue_s i);
        logic [7:0] sh;
        unique case (i.op)
            vxu_pkg::VXU_FPU_FADD: return fAdd(i.a, i.b);
            vxu_pkg::VXU_FPU_FSUB: return fAdd(i.a, {~i.b[31], i.b[30:0]});
            vxu_pkg::VXU_FPU_I2F:  return (i.a[31:26] != 6'h00) ? fNorm(1'b0, 9'h09C, i.a[31:6])
                                                               : fNorm(1'b0, 9'h096, i.a[25:0]);
            vxu_pkg::VXU_FPU_F2I:  begin
                sh = i.a[30:23] - 8'h7F;
                if (i.a[30:23] < 8'h7F) begin
                    return '0;
                end
                if (sh > 8'h1E) begin
                    return 32'h7FFFFFFF;
                end
                return 32'(({40'h0, 1'b1, i.a[22:0]} << sh) >> 23);
            end
            default:               return '0;
        endcase
    endfunction : fpuCalc

    function automatic vxu_pkg::vxu_word_t mulCalc(input vxu_pkg::vxu_mulissue_s i);
        logic [63:0] p;
        logic [47:0] fm;
        unique case (i.op)
            vxu_pkg::VXU_MUL_MUL: begin
                p = i.a * i.b;
                return p[31:0];
            end
            vxu_pkg::VXU_MUL_MUL16:
                return {16'(i.a[31:16] * i.b[31:16]), 16'(i.a[15:0] * i.b[15:0])};
            // Two-lane multiply-add into one sum
            vxu_pkg::VXU_MUL_DOT16:
                return 32'(i.a[31:16] * i.b[31:16]) + 32'(i.a[15:0] * i.b[15:0]);
            vxu_pkg::VXU_MUL_FMUL: begin
                if (i.a[30:0] == '0 || i.b[30:0] == '0) begin
                    return '0;
                end
                fm = {1'b1, i.a[22:0]} * {1'b1, i.b[22:0]};
                return fNorm(i.a[31] ^ i.b[31],
                             9'({1'b0, i.a[30:23]} + {1'b0, i.b[30:23]}) - 9'h07F,
                             fm[47:22]) - 32'h00800000;
            end
            default: return '0;
        endcase
    endfunction : mulCalc

    function automatic vxu_pkg::vxu_word_t divCalc(input vxu_pkg::vxu_divissue_s i);
        logic signed [31:0] sa;
        logic signed [31:0] sb;
        sa = i.a;
        sb = i.b;
        // Divide by zero gives all ones rather than a trap
        if (i.b == '0) begin
            return 32'hFFFFFFFF;
        end
        unique case (i.op)
            vxu_pkg::VXU_DIV_DIVS: return sa / sb;
            vxu_pkg::VXU_DIV_DIVU: return i.a / i.b;
            vxu_pkg::VXU_DIV_REMS: return sa % sb;
            vxu_pkg::VXU_DIV_REMU: return i.a % i.b;
            default:               return '0;
        endcase
    endfunction : divCalc

    ////////////////////////////////////////////////////////////////////////////
    // Issue and stall

    logic       divSlowStage [D];
    logic [7:0] divWait;
    logic       take;
    logic       slowHere;

    vxu_pkg::vxu_alures_s aluQ [NA];
    vxu_pkg::vxu_res_s    mulQ [NM][D];
    vxu_pkg::vxu_res_s    fpuQ [NF][D];
    vxu_pkg::vxu_res_s    divQ [D];
    vxu_pkg::vxu_res_s    divLast;

    assign divLast = divQ[D-1];

    // Signed ops with a negative operand take the long path
    assign slowHere   = divIn.valid && !divIn.op[0] && (divIn.a[31] || divIn.b[31]);
    assign stall      = divLast.valid && divSlowStage[D-1] && (divWait != 8'(DIV_EXTRA)); // [RL15]
    assign issueReady = !stall; // [RL16]
    assign take       = issueValid && !stall; // [RL2] [RL16]

    ////////////////////////////////////////////////////////////////////////////
    // Pipelines

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aluQ <= '{default: '0};
            mulQ <= '{default: '0};
            fpuQ <= '{default: '0};
            divQ <= '{default: '0};
            divSlowStage <= '{default: 1'b0};
            divWait <= 8'h00;
        end else if (stall) begin
            divWait <= divWait + 8'h01; // [RL15] [RL16]
        end else begin
            divWait <= 8'h00;
            for (int u = 0; u < NA; u++) begin
                aluQ[u] <= (take && aluIn[u].valid) ? aluCalc(aluIn[u]) : '0; // [RL3] [RL4] [RL5] [RL6]
            end
            for (int u = 0; u < NM; u++) begin
                mulQ[u][0] <= '{take && mulIn[u].valid, mulCalc(mulIn[u])}; // [RL10] [RL11] [RL12]
                for (int s = 1; s < D; s++) begin
                    mulQ[u][s] <= mulQ[u][s-1];
                end
            end
            for (int u = 0; u < NF; u++) begin
                fpuQ[u][0] <= '{take && fpuIn[u].valid, fpuCalc(fpuIn[u])}; // [RL7] [RL8] [RL9]
                for (int s = 1; s < D; s++) begin
                    fpuQ[u][s] <= fpuQ[u][s-1];
                end
            end
            divQ[0] <= '{take && divIn.valid, divCalc(divIn)}; // [RL13] [RL14]
            divSlowStage[0] <= take && slowHere;
            for (int s = 1; s < D; s++) begin
                divQ[s] <= divQ[s-1];
                divSlowStage[s] <= divSlowStage[s-1];
            end
        end
    end

    // Valid is masked while stalled so each result is seen once
    always_comb begin
        for (int u = 0; u < NA; u++) begin
            aluRes[u] = aluQ[u];
            aluRes[u].valid = aluQ[u].valid && !stall;
            aluRes[u].condValid = aluQ[u].condValid && !stall;
        end
        for (int u = 0; u < NM; u++) begin
            mulRes[u] = '{mulQ[u][D-1].valid && !stall, mulQ[u][D-1].data};
        end
        for (int u = 0; u < NF; u++) begin
            fpuRes[u] = '{fpuQ[u][D-1].valid && !stall, fpuQ[u][D-1].data};
        end
        divRes = '{divLast.valid && !stall, divLast.data};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    wire vxu_pkg::vxu_word_t mulNow0 = mulCalc(mulIn[0]);
    wire vxu_pkg::vxu_word_t divNow  = divCalc(divIn);

    sequence sMulIssue;
        take && mulIn[0].valid;
    endsequence

    sequence sNoStall3;
        !stall [*3];
    endsequence

    a_alu_next_cycle: assert property ( // [RL4]
        take && aluIn[0].valid && aluIn[0].op == vxu_pkg::VXU_ALU_ADD ##1 !stall
        |-> aluRes[0].valid && aluRes[0].data == $past(aluIn[0].a) + $past(aluIn[0].b))
        else $error("ALU result not ready next cycle");
    a_alu_cond_only: assert property ( // [RL6]
        take && aluIn[1].valid && aluIn[1].op == vxu_pkg::VXU_ALU_CMPEQ ##1 !stall
        |-> !aluRes[1].valid && aluRes[1].condValid)
        else $error("Compare did not give a condition only");
    a_mul_three_deep: assert property (sMulIssue ##1 sNoStall3 // [RL10]
        |-> mulRes[0].valid && mulRes[0].data == $past(mulNow0, 3))
        else $error("Multiply result not after three cycles");
    a_mul_back_back: assert property (sMulIssue ##1 sMulIssue ##1 sNoStall3 // [RL10]
        |-> mulRes[0].valid)
        else $error("Multiplier lost a back to back issue");
    a_fpu_three_deep: assert property (take && fpuIn[1].valid ##1 sNoStall3 // [RL8]
        |-> fpuRes[1].valid)
        else $error("FPU result not after three cycles");
    a_fpu_no_early: assert property (take && !fpuIn[0].valid ##1 sNoStall3 // [RL8]
        |-> !fpuRes[0].valid)
        else $error("FPU result without an issue");
    a_div_fast_path: assert property ( // [RL13] [RL14]
        take && divIn.valid && !slowHere ##1 sNoStall3
        |-> divRes.valid && divRes.data == $past(divNow, 3))
        else $error("Fast divide not after three cycles");
    a_div_stall_len: assert property ($rose(stall) |-> stall [*2] ##1 !stall) // [RL15]
        else $error("Divide stall length wrong");
    a_stall_refuse: assert property (stall |-> !issueReady && !divRes.valid && !aluRes[0].valid) // [RL16]
        else $error("Issue or result seen during stall");
    a_stall_hold: assert property (stall |=> $stable(mulQ[0][D-1]) && $stable(fpuQ[0][D-1])) // [RL16]
        else $error("Pipeline moved during stall");

endmodule : vxu_exec_cluster

`default_nettype wire

// file: rtl/vxu_map.svh
`ifndef VXU_MAP_SVH
`define VXU_MAP_SVH

// Unit counts in one bundle
`define VXU_NUM_ALU     4
`define VXU_NUM_MUL     2
`define VXU_NUM_FPU     2
// Latencies in core clock cycles
`define VXU_ALU_LAT     1
`define VXU_PIPE_DEPTH  3
// Extra divider cycles for a slow case
`define VXU_DIV_EXTRA   2
// Operand widths
`define VXU_WORD_W      32
`define VXU_COND_W      4

`endif

// file: rtl/vxu_pkg.sv
`default_nettype none
`include "vxu_map.svh"

package vxu_pkg;

    typedef logic [`VXU_WORD_W-1:0] vxu_word_t;
    typedef logic [`VXU_COND_W-1:0] vxu_cond_t;

    typedef enum logic [3:0] {
        VXU_ALU_ADD   = 4'h0,
        VXU_ALU_SUB   = 4'h1,
        VXU_ALU_AND   = 4'h2,
        VXU_ALU_OR    = 4'h3,
        VXU_ALU_XOR   = 4'h4,
        VXU_ALU_SHL   = 4'h5,
        VXU_ALU_SHR   = 4'h6,
        VXU_ALU_ADD8  = 4'h7,
        VXU_ALU_ADD16 = 4'h8,
        VXU_ALU_CMPEQ = 4'h9,
        VXU_ALU_SEL   = 4'hA,
        VXU_ALU_CAND  = 4'hB
    } vxu_aluop_e;

    typedef enum logic [1:0] {
        VXU_MUL_MUL   = 2'h0,
        VXU_MUL_MUL16 = 2'h1,
        VXU_MUL_DOT16 = 2'h2,
        VXU_MUL_FMUL  = 2'h3
    } vxu_mulop_e;

    typedef enum logic [1:0] {
        VXU_FPU_FADD = 2'h0,
        VXU_FPU_FSUB = 2'h1,
        VXU_FPU_I2F  = 2'h2,
        VXU_FPU_F2I  = 2'h3
    } vxu_fpuop_e;

    typedef enum logic [1:0] {
        VXU_DIV_DIVS = 2'h0,
        VXU_DIV_DIVU = 2'h1,
        VXU_DIV_REMS = 2'h2,
        VXU_DIV_REMU = 2'h3
    } vxu_divop_e;

    typedef struct packed {
        logic       valid;
        vxu_aluop_e op;
        vxu_word_t  a;
        vxu_word_t  b;
        vxu_cond_t  ca;
        vxu_cond_t  cb;
    } vxu_aluissue_s;

    typedef struct packed {
        logic       valid;
        vxu_mulop_e op;
        vxu_word_t  a;
        vxu_word_t  b;
    } vxu_mulissue_s;

    typedef struct packed {
        logic       valid;
        vxu_fpuop_e op;
        vxu_word_t  a;
        vxu_word_t  b;
    } vxu_fpuissue_s;

    typedef struct packed {
        logic       valid;
        vxu_divop_e op;
        vxu_word_t  a;
        vxu_word_t  b;
    } vxu_divissue_s;

    typedef struct packed {
        logic      valid;
        logic      condValid;
        vxu_word_t data;
        vxu_cond_t cond;
    } vxu_alures_s;

    typedef struct packed {
        logic      valid;
        vxu_word_t data;
    } vxu_res_s;

endpackage : vxu_pkg

`default_nettype wire

// file: testbench/test_vliw_execution_units.sv
`default_nettype none
`include "vxu_map.svh"

module test_vliw_execution_units;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DivExtra = 2;

    ////////////////////////////////////////////////////////////////////////////
    logic                   clk    = 1'b0;
    logic                   resetn = 1'b0;
    logic                   offer  = 1'b0;
    logic                   issueValid;
    logic                   issueReady;
    logic                   stall;
    vxu_pkg::vxu_aluissue_s reqAlu [`VXU_NUM_ALU];
    vxu_pkg::vxu_mulissue_s reqMul [`VXU_NUM_MUL];
    vxu_pkg::vxu_fpuissue_s reqFpu [`VXU_NUM_FPU];
    vxu_pkg::vxu_divissue_s reqDiv;
    vxu_pkg::vxu_aluissue_s aluIn  [`VXU_NUM_ALU];
    vxu_pkg::vxu_mulissue_s mulIn  [`VXU_NUM_MUL];
    vxu_pkg::vxu_fpuissue_s fpuIn  [`VXU_NUM_FPU];
    vxu_pkg::vxu_divissue_s divIn;
    vxu_pkg::vxu_alures_s   aluRes [`VXU_NUM_ALU];
    vxu_pkg::vxu_res_s      mulRes [`VXU_NUM_MUL];
    vxu_pkg::vxu_res_s      fpuRes [`VXU_NUM_FPU];
    vxu_pkg::vxu_res_s      divRes;
    int                     numErrors = 0;
    int                     testsRun  = 0;

    always #10 clk = ~clk;

    vxu_issue_model i_partner (
        .offer      (offer),
        .reqAlu     (reqAlu),
        .reqMul     (reqMul),
        .reqFpu     (reqFpu),
        .reqDiv     (reqDiv),
        .issueValid (issueValid),
        .aluIn      (aluIn),
        .mulIn      (mulIn),
        .fpuIn      (fpuIn),
        .divIn      (divIn)
    );

    vxu_exec_cluster #(
        .DIV_EXTRA (DivExtra)
    ) i_dut (
        .clk        (clk),
        .resetn     (resetn),
        .issueValid (issueValid),
        .issueReady (issueReady),
        .aluIn      (aluIn),
        .mulIn      (mulIn),
        .fpuIn      (fpuIn),
        .divIn      (divIn),
        .aluRes     (aluRes),
        .mulRes     (mulRes),
        .fpuRes     (fpuRes),
        .divRes     (divRes),
        .stall      (stall)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic finishTest();
        $display("errors=%0d checks=%0d", numErrors, testsRun);
        if (numErrors == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finishTest

    // Inputs change and outputs are read one step after each rising edge
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic clearReq();
        reqAlu = '{default: '0};
        reqMul = '{default: '0};
        reqFpu = '{default: '0};
        reqDiv = '0;
    endtask : clearReq

    task automatic idle();
        offer = 1'b0;
        clearReq();
    endtask : idle

    // Holds the bundle while refused; returns in the cycle after it is taken
    task automatic issue();
        int n;
        n = 0;
        offer = 1'b1;
        while (issueReady !== 1'b1) begin
            n++;
            if (n > 20) begin
                numErrors++;
                finishTest();
            end
            tick();
        end
        tick();
    endtask : issue

    // The select source is fixed low, so select always yields b
    function automatic logic [31:0] aluExp(vxu_pkg::vxu_aluop_e op, logic [31:0] a, b);
        case (op)
            vxu_pkg::VXU_ALU_ADD: return a + b;
            vxu_pkg::VXU_ALU_SUB: return a - b;
            vxu_pkg::VXU_ALU_AND: return a & b;
            vxu_pkg::VXU_ALU_OR:  return a | b;
            vxu_pkg::VXU_ALU_XOR: return a ^ b;
            vxu_pkg::VXU_ALU_SEL: return b;
            vxu_pkg::VXU_ALU_SHL: return a << b[4:0];
            vxu_pkg::VXU_ALU_SHR: return a >> b[4:0];
            vxu_pkg::VXU_ALU_ADD16: return {a[31:16] + b[31:16], a[15:0] + b[15:0]};
            default:              return {a[31:24] + b[31:24], a[23:16] + b[23:16],
                                          a[15:8] + b[15:8], a[7:0] + b[7:0]};
        endcase
    endfunction : aluExp

    ////////////////////////////////////////////////////////////////////////////
    task automatic testAlu();
        vxu_pkg::vxu_aluop_e ops [12] = '{vxu_pkg::VXU_ALU_ADD, vxu_pkg::VXU_ALU_SUB,
            vxu_pkg::VXU_ALU_AND, vxu_pkg::VXU_ALU_OR, vxu_pkg::VXU_ALU_XOR,
            vxu_pkg::VXU_ALU_CMPEQ, vxu_pkg::VXU_ALU_SEL, vxu_pkg::VXU_ALU_ADD8,
            vxu_pkg::VXU_ALU_SHL, vxu_pkg::VXU_ALU_SHR, vxu_pkg::VXU_ALU_ADD16,
            vxu_pkg::VXU_ALU_CAND};
        logic [31:0]         a   [12];
        logic [31:0]         b   [12];
        int                  j;
        tick();
        for (int k = 0; k < 12; k++) begin
            a[k] = 32'h8F0012F0 + k;
            b[k] = (k == 5) ? a[k] : 32'h0F00FF31;
            reqAlu[k % 4] = '{1'b1, ops[k], a[k], b[k], 4'hC, 4'hA};
            if (k % 4 == 3) begin
                issue();
                for (int u = 0; u < 4; u++) begin
                    j = k - 3 + u;
                    if (ops[j] == vxu_pkg::VXU_ALU_CMPEQ) begin
                        check({aluRes[u].valid, aluRes[u].condValid, aluRes[u].cond[0]}, 3'h3);
                    end else if (ops[j] == vxu_pkg::VXU_ALU_CAND) begin
                        check({aluRes[u][37:36], aluRes[u].cond}, 6'h18);
                    end else begin
                        check({aluRes[u].valid, aluRes[u].data}, {1'b1, aluExp(ops[j], a[j], b[j])});
                    end
                end
            end
        end
        idle();
        tick();
        check(aluRes[0].valid, 1'b0);
    endtask : testAlu

    task automatic testPipes();
        vxu_pkg::vxu_fpuop_e fo  [6] = '{vxu_pkg::VXU_FPU_FADD, vxu_pkg::VXU_FPU_FSUB,
            vxu_pkg::VXU_FPU_I2F, vxu_pkg::VXU_FPU_F2I, vxu_pkg::VXU_FPU_FADD, vxu_pkg::VXU_FPU_FSUB};
        vxu_pkg::vxu_divop_e dop [3] = '{vxu_pkg::VXU_DIV_DIVU, vxu_pkg::VXU_DIV_REMU,
            vxu_pkg::VXU_DIV_REMS};
        logic [31:0] fa [6] = '{32'h3F800000, 32'h40400000, 32'h00000005, 32'h40A00000,
            32'h40000000, 32'h40800000};
        logic [31:0] fb [6] = '{32'h40000000, 32'h3F800000, 32'h00000000, 32'h00000000,
            32'h40000000, 32'h3F800000};
        logic [31:0] fe [6] = '{32'h40400000, 32'h40000000, 32'h40A00000, 32'h00000005,
            32'h40800000, 32'h40400000};
        logic [31:0] de [3] = '{32'h0000000E, 32'h00000002, 32'h00000001};
        logic [31:0] e  [3][5];
        vxu_pkg::vxu_res_s r [5];
        tick();
        for (int k = 0; k < 6; k++) begin
            if (k < 3) begin
                reqMul[0] = '{1'b1, vxu_pkg::VXU_MUL_MUL, 32'h00000103 + k, 32'h00012345};
                if (k == 1) begin
                    reqMul[1] = '{1'b1, vxu_pkg::VXU_MUL_FMUL, 32'h40000000, 32'h40400000};
                end else if (k == 2) begin
                    reqMul[1] = '{1'b1, vxu_pkg::VXU_MUL_MUL16, 32'h00020005, 32'h00040005};
                end else begin
                    reqMul[1] = '{1'b1, vxu_pkg::VXU_MUL_DOT16, 32'h00020003 + k, 32'h00040005};
                end
                reqFpu[0] = '{1'b1, fo[k], fa[k], fb[k]};
                reqFpu[1] = '{1'b1, fo[k + 3], fa[k + 3], fb[k + 3]};
                reqDiv = '{1'b1, dop[k], (k == 2) ? 32'h00000032 : 32'h00000064, 32'h00000007};
                e[k] = '{(32'h00000103 + k) * 32'h00012345,
                         (k == 0) ? 32'h00000017 : (k == 1) ? 32'h40C00000 : 32'h00080019,
                         fe[k], fe[k + 3], de[k]};
                issue();
            end else begin
                if (k == 3) begin
                    idle();
                end
                tick();
            end
            r = '{mulRes[0], mulRes[1], fpuRes[0], fpuRes[1], divRes};
            check(stall, 1'b0);
            for (int u = 0; u < 5; u++) begin
                if (k >= 2 && k <= 4) begin
                    check({r[u].valid, r[u].data}, {1'b1, e[k - 2][u]});
                end else begin
                    check(r[u].valid, 1'b0);
                end
            end
        end
    endtask : testPipes

    // A signed divide of a negative value takes the slow path and freezes all units
    task automatic testSlow();
        tick();
        reqDiv    = '{1'b1, vxu_pkg::VXU_DIV_DIVS, 32'hFFFFFF9C, 32'h00000007};
        reqMul[0] = '{1'b1, vxu_pkg::VXU_MUL_MUL, 32'h00000003, 32'h00000005};
        issue();
        reqDiv    = '0;
        reqMul[0] = '0;
        tick();
        check(stall, 1'b0);
        tick();
        reqAlu[0] = '{1'b1, vxu_pkg::VXU_ALU_ADD, 32'h00000002, 32'h00000003, 4'h0, 4'h0};
        for (int j = 0; j < DivExtra; j++) begin
            check({stall, issueReady, divRes.valid, mulRes[0].valid}, 4'h8);
            tick();
        end
        check({stall, divRes.valid, mulRes[0].valid, aluRes[0].valid}, 4'h6);
        check(divRes.data, 32'hFFFFFFF2);
        check(mulRes[0].data, 32'h0000000F);
        tick();
        check({aluRes[0].valid, aluRes[0].data}, {1'b1, 32'h00000005});
        idle();
    endtask : testSlow

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clearReq();
        repeat (12) @(posedge clk);
        #1;
        check({issueReady, stall, aluRes[0].valid, divRes.valid}, 4'h8);
        resetn = 1'b1;
        testAlu();
        testPipes();
        testSlow();
        finishTest();
    end

endmodule : test_vliw_execution_units

`default_nettype wire

// file: testbench/vxu_issue_model.sv
`default_nettype none
`include "vxu_map.svh"

module vxu_issue_model (
    // Bundle prepared by the bench
    input  wire logic                   offer,
    input  wire vxu_pkg::vxu_aluissue_s reqAlu [`VXU_NUM_ALU],
    input  wire vxu_pkg::vxu_mulissue_s reqMul [`VXU_NUM_MUL],
    input  wire vxu_pkg::vxu_fpuissue_s reqFpu [`VXU_NUM_FPU],
    input  wire vxu_pkg::vxu_divissue_s reqDiv,
    // Issue side of the cluster
    output var  logic                   issueValid,
    output var  vxu_pkg::vxu_aluissue_s aluIn  [`VXU_NUM_ALU],
    output var  vxu_pkg::vxu_mulissue_s mulIn  [`VXU_NUM_MUL],
    output var  vxu_pkg::vxu_fpuissue_s fpuIn  [`VXU_NUM_FPU],
    output var  vxu_pkg::vxu_divissue_s divIn
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Slot counts are fixed by the port arrays, so no unit is oversubscribed
    assign issueValid = offer;

    // While no bundle is offered, every slot shows inverted operands with valid low, so stale values never look valid
    for (genvar i = 0; i < `VXU_NUM_ALU; i++) begin : g_alu
        assign aluIn[i] = offer ? reqAlu[i] : vxu_pkg::vxu_aluissue_s'({1'b0, ~reqAlu[i][75:0]});
    end
    for (genvar i = 0; i < `VXU_NUM_MUL; i++) begin : g_mul
        assign mulIn[i] = offer ? reqMul[i] : vxu_pkg::vxu_mulissue_s'({1'b0, ~reqMul[i][65:0]});
    end
    for (genvar i = 0; i < `VXU_NUM_FPU; i++) begin : g_fpu
        assign fpuIn[i] = offer ? reqFpu[i] : vxu_pkg::vxu_fpuissue_s'({1'b0, ~reqFpu[i][65:0]});
    end
    assign divIn = offer ? reqDiv : vxu_pkg::vxu_divissue_s'({1'b0, ~reqDiv[65:0]});

endmodule : vxu_issue_model

`default_nettype wire
